// ==== gpc_consts.svh ====
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ==========================================================================
// widths
`define GPC_PORT_W 8
`define GPC_ADDR_W 32
`define GPC_DATA_W 32
`define GPC_CH_N 2

// ==========================================================================
// register byte addresses
`define GPC_PORTC_OPEN_DRAIN_SELECT_ADDR 32'h400c0228
`define GPC_PORTC_PULLUP_ENABLE_ADDR 32'h400c022c
`define GPC_PORTC_INPUT_ENABLE_ADDR 32'h400c0238
`define GPC_PORTD_PIN_DATA_ADDR 32'h400c0300
`define GPC_PORTD_OUTPUT_ENABLE_ADDR 32'h400c0304
`define GPC_PORTD_FUNCTION_SELECT_ONE_ADDR 32'h400c0308
`define GPC_PORTD_FUNCTION_SELECT_TWO_ADDR 32'h400c030c
`define GPC_PORTD_FUNCTION_SELECT_THREE_ADDR 32'h400c0310

// ==========================================================================
// reset values and writable masks
`define GPC_REG_RESET 8'h00
`define GPC_PIN_RESET 8'h00
`define GPC_FS_TWO_MASK 8'hf7
`define GPC_FS_THREE_MASK 8'h44

// ==========================================================================
// second function-select bit roles
`define GPC_FS_TWO_TX_MASK 8'h11
`define GPC_FS_TWO_SCLK_MASK 8'h44
`define GPC_CH10_TX_BIT 0
`define GPC_CH10_RX_BIT 1
`define GPC_CH10_CLK_BIT 2
`define GPC_CH11_TX_BIT 4
`define GPC_CH11_RX_BIT 5
`define GPC_CH11_CLK_BIT 6
`define GPC_INT_BIT 7
`define GPC_CH_SPAN 4

`endif

// ==== gpc_pkg.sv ====
package gpc_pkg;

  typedef logic [7:0] gpc_byte_t;

  typedef struct packed {
    gpc_byte_t s1;
    gpc_byte_t s2;
    gpc_byte_t s3;
    gpc_byte_t stable;
  } gpc_sync_s;

  typedef struct packed {
    gpc_byte_t pin_data;
    gpc_byte_t out_en;
    gpc_byte_t fs_one;
    gpc_byte_t fs_two;
    gpc_byte_t fs_three;
    gpc_byte_t c_open_drain;
    gpc_byte_t c_pullup;
    gpc_byte_t c_input_en;
    logic [31:0] rdata;
    gpc_byte_t pd_out;
    gpc_byte_t pd_oe_n;
    logic [1:0] rx;
    logic [1:0] cts;
    logic [1:0] sclk_in;
    logic ext_int;
  } gpc_state_s;

endpackage

// ==== gpc_pad_if.sv ====
`timescale 1ns/1ns
interface gpc_pad_if;
  import gpc_pkg::*;
  gpc_byte_t pin_data;
  gpc_byte_t out_en;
  gpc_byte_t fs_one;
  gpc_byte_t fs_two;
  gpc_byte_t fs_three;
  gpc_byte_t pin_level;
  gpc_byte_t addr_line;
  logic [1:0] tx;
  logic [1:0] sclk_out;
  logic [1:0] sclk_oe;
  gpc_byte_t nxt_out;
  gpc_byte_t nxt_drive;
  logic [1:0] nxt_rx;
  logic [1:0] nxt_cts;
  logic [1:0] nxt_sclk_in;
  logic nxt_int;

  modport ctl (
    output pin_data, out_en, fs_one, fs_two, fs_three, pin_level, addr_line, tx, sclk_out, sclk_oe,
    input nxt_out, nxt_drive, nxt_rx, nxt_cts, nxt_sclk_in, nxt_int
  );
  modport mux (
    input pin_data, out_en, fs_one, fs_two, fs_three, pin_level, addr_line, tx, sclk_out, sclk_oe,
    output nxt_out, nxt_drive, nxt_rx, nxt_cts, nxt_sclk_in, nxt_int
  );
endinterface

// ==== gpc_sync.sv ====
`timescale 1ns/1ns
`include "gpc_consts.svh"
module gpc_sync
  import gpc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire gpc_byte_t async_i,
  output gpc_byte_t sync_o
);

  gpc_sync_s st_ff;
  gpc_sync_s nxt_st;

  // ==========================================================================
  // three-stage capture, accept once stages two and three agree
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < `GPC_PORT_W; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.stable[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.stable;

endmodule // gpc_sync

// ==== gpc_pad_mux.sv ====
`timescale 1ns/1ns
`include "gpc_consts.svh"
module gpc_pad_mux
  import gpc_pkg::*;
(
  gpc_pad_if.mux pad
);

  localparam gpc_byte_t TX_MASK = `GPC_FS_TWO_TX_MASK;
  localparam gpc_byte_t SCLK_MASK = `GPC_FS_TWO_SCLK_MASK;

  // ==========================================================================
  // per-pin output select
  for (genvar i = 0; i < `GPC_PORT_W; i++)
  begin : g_pin
    localparam int CH = i / `GPC_CH_SPAN;
    always_comb
    begin
      pad.nxt_out[i] = pad.pin_data[i];
      pad.nxt_drive[i] = pad.out_en[i];
      if (pad.fs_one[i])
      begin
        pad.nxt_out[i] = pad.addr_line[i];
        pad.nxt_drive[i] = pad.out_en[i];
      end
      else if (pad.fs_two[i] && TX_MASK[i])
      begin
        pad.nxt_out[i] = pad.tx[CH];
        pad.nxt_drive[i] = pad.out_en[i];
      end
      else if (pad.fs_two[i] && SCLK_MASK[i])
      begin
        pad.nxt_out[i] = pad.sclk_out[CH];
        pad.nxt_drive[i] = pad.out_en[i] & pad.sclk_oe[CH];
      end
      else if (pad.fs_two[i])
      begin
        pad.nxt_drive[i] = 1'b0;
      end
      else if (pad.fs_three[i])
      begin
        pad.nxt_drive[i] = 1'b0;
      end
    end
  end

  // ==========================================================================
  // alternate-function inputs
  assign pad.nxt_rx[0] = (pad.fs_two[`GPC_CH10_RX_BIT] && !pad.fs_one[`GPC_CH10_RX_BIT]) ?
    pad.pin_level[`GPC_CH10_RX_BIT] : 1'b1;
  assign pad.nxt_rx[1] = (pad.fs_two[`GPC_CH11_RX_BIT] && !pad.fs_one[`GPC_CH11_RX_BIT]) ?
    pad.pin_level[`GPC_CH11_RX_BIT] : 1'b1;
  assign pad.nxt_sclk_in[0] = (pad.fs_two[`GPC_CH10_CLK_BIT] && !pad.fs_one[`GPC_CH10_CLK_BIT]) ?
    pad.pin_level[`GPC_CH10_CLK_BIT] : 1'b0;
  assign pad.nxt_sclk_in[1] = (pad.fs_two[`GPC_CH11_CLK_BIT] && !pad.fs_one[`GPC_CH11_CLK_BIT]) ?
    pad.pin_level[`GPC_CH11_CLK_BIT] : 1'b0;
  assign pad.nxt_cts[0] = (pad.fs_three[`GPC_CH10_CLK_BIT] && !pad.fs_two[`GPC_CH10_CLK_BIT] &&
    !pad.fs_one[`GPC_CH10_CLK_BIT]) ? pad.pin_level[`GPC_CH10_CLK_BIT] : 1'b1;
  assign pad.nxt_cts[1] = (pad.fs_three[`GPC_CH11_CLK_BIT] && !pad.fs_two[`GPC_CH11_CLK_BIT] &&
    !pad.fs_one[`GPC_CH11_CLK_BIT]) ? pad.pin_level[`GPC_CH11_CLK_BIT] : 1'b1;
  assign pad.nxt_int = (pad.fs_two[`GPC_INT_BIT] && !pad.fs_one[`GPC_INT_BIT]) ?
    pad.pin_level[`GPC_INT_BIT] : 1'b0;

endmodule // gpc_pad_mux

// ==== gpc_port.sv ====
// Functional notes
// - eight pins, each carried by one bit of the port data register
// - direction chosen per pin, one bit each
// - reset leaves every pin in port mode, buffers and pull-ups off
// - direction bit zero disables driver, one enables unless pin has an input function or a low clock oe; resets zero
// - first function bit one puts address line A(9+n) on pin n
// - second function bits select ch10, ch11 serial and interrupt; bit 3 reads zero
// - open-drain bit zero push-pull, one open-drain; resets zero
// - pull-up bit zero off, one on; resets zero
// - input-enable bit zero blocks buffer, one enables; resets zero
`timescale 1ns/1ns
`include "gpc_consts.svh"
module gpc_port
  import gpc_pkg::*;
#(
  parameter int ADDR_W = `GPC_ADDR_W,
  parameter int DATA_W = `GPC_DATA_W
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [7:0] pd_in_i,
  output logic [7:0] pd_out_o,
  output logic [7:0] pd_oe_n_o,
  input wire logic [7:0] ext_addr_i,
  input wire logic serial_ch10_transmit_i,
  input wire logic serial_ch11_transmit_i,
  input wire logic serial_ch10_clock_out_i,
  input wire logic serial_ch11_clock_out_i,
  input wire logic serial_ch10_clock_oe_i,
  input wire logic serial_ch11_clock_oe_i,
  output logic serial_ch10_receive_o,
  output logic serial_ch11_receive_o,
  output logic serial_ch10_clock_o,
  output logic serial_ch11_clock_o,
  output logic serial_ch10_clear_to_send_o,
  output logic serial_ch11_clear_to_send_o,
  output logic external_interrupt_input_o,
  output logic [7:0] portc_open_drain_o,
  output logic [7:0] portc_pullup_o,
  output logic [7:0] portc_input_en_o
);

  gpc_state_s st_ff;
  gpc_state_s nxt_st;
  gpc_byte_t pin_sync;
  gpc_byte_t wbyte;
  logic [31:0] rd_word;

  gpc_pad_if pad ();

  // ==========================================================================
  // pin input synchroniser
  gpc_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pd_in_i),
    .sync_o(pin_sync)
  );

  // ==========================================================================
  // pin function mux
  assign pad.pin_data = st_ff.pin_data;
  assign pad.out_en = st_ff.out_en;
  assign pad.fs_one = st_ff.fs_one;
  assign pad.fs_two = st_ff.fs_two;
  assign pad.fs_three = st_ff.fs_three;
  assign pad.pin_level = pin_sync;
  assign pad.addr_line = ext_addr_i;
  assign pad.tx = {serial_ch11_transmit_i, serial_ch10_transmit_i};
  assign pad.sclk_out = {serial_ch11_clock_out_i, serial_ch10_clock_out_i};
  assign pad.sclk_oe = {serial_ch11_clock_oe_i, serial_ch10_clock_oe_i};

  gpc_pad_mux u_mux (
    .pad(pad.mux)
  );

  assign wbyte = wdata_i[7:0];

  // ==========================================================================
  // read multiplexer
  always_comb
  begin
    rd_word = '0;
    // data reads driven value or pin level
    if (addr_i == `GPC_PORTD_PIN_DATA_ADDR)
    begin
      rd_word[7:0] = (st_ff.pin_data & st_ff.out_en) | (pin_sync & ~st_ff.out_en);
    end
    else if (addr_i == `GPC_PORTD_OUTPUT_ENABLE_ADDR)
    begin
      rd_word[7:0] = st_ff.out_en;
    end
    else if (addr_i == `GPC_PORTD_FUNCTION_SELECT_ONE_ADDR)
    begin
      rd_word[7:0] = st_ff.fs_one;
    end
    else if (addr_i == `GPC_PORTD_FUNCTION_SELECT_TWO_ADDR)
    begin
      rd_word[7:0] = st_ff.fs_two;
    end
    else if (addr_i == `GPC_PORTD_FUNCTION_SELECT_THREE_ADDR)
    begin
      rd_word[7:0] = st_ff.fs_three;
    end
    else if (addr_i == `GPC_PORTC_OPEN_DRAIN_SELECT_ADDR)
    begin
      rd_word[7:0] = st_ff.c_open_drain;
    end
    else if (addr_i == `GPC_PORTC_PULLUP_ENABLE_ADDR)
    begin
      rd_word[7:0] = st_ff.c_pullup;
    end
    else if (addr_i == `GPC_PORTC_INPUT_ENABLE_ADDR)
    begin
      rd_word[7:0] = st_ff.c_input_en;
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = rd_i ? rd_word : 32'h0000_0000;
    if (wr_i)
    begin
      if (addr_i == `GPC_PORTD_PIN_DATA_ADDR)
      begin
        nxt_st.pin_data = wbyte;
      end
      else if (addr_i == `GPC_PORTD_OUTPUT_ENABLE_ADDR)
      begin
        nxt_st.out_en = wbyte;
      end
      else if (addr_i == `GPC_PORTD_FUNCTION_SELECT_ONE_ADDR)
      begin
        nxt_st.fs_one = wbyte;
      end
      else if (addr_i == `GPC_PORTD_FUNCTION_SELECT_TWO_ADDR)
      begin
        nxt_st.fs_two = wbyte & `GPC_FS_TWO_MASK;
      end
      else if (addr_i == `GPC_PORTD_FUNCTION_SELECT_THREE_ADDR)
      begin
        nxt_st.fs_three = wbyte & `GPC_FS_THREE_MASK;
      end
      else if (addr_i == `GPC_PORTC_OPEN_DRAIN_SELECT_ADDR)
      begin
        nxt_st.c_open_drain = wbyte;
      end
      else if (addr_i == `GPC_PORTC_PULLUP_ENABLE_ADDR)
      begin
        nxt_st.c_pullup = wbyte;
      end
      else if (addr_i == `GPC_PORTC_INPUT_ENABLE_ADDR)
      begin
        nxt_st.c_input_en = wbyte;
      end
    end
    nxt_st.pd_out = pad.nxt_out;
    nxt_st.pd_oe_n = ~pad.nxt_drive;
    nxt_st.rx = pad.nxt_rx;
    nxt_st.cts = pad.nxt_cts;
    nxt_st.sclk_in = pad.nxt_sclk_in;
    nxt_st.ext_int = pad.nxt_int;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_ff.pin_data <= `GPC_PIN_RESET;
      st_ff.out_en <= `GPC_REG_RESET;
      st_ff.fs_one <= `GPC_REG_RESET;
      st_ff.fs_two <= `GPC_REG_RESET;
      st_ff.fs_three <= `GPC_REG_RESET;
      st_ff.c_open_drain <= `GPC_REG_RESET;
      st_ff.c_pullup <= `GPC_REG_RESET;
      st_ff.c_input_en <= `GPC_REG_RESET;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.pd_out <= 8'h00;
      st_ff.pd_oe_n <= 8'hff;
      st_ff.rx <= 2'h3;
      st_ff.cts <= 2'h3;
      st_ff.sclk_in <= 2'h0;
      st_ff.ext_int <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata_o = DATA_W'(st_ff.rdata);
  assign pd_out_o = st_ff.pd_out;
  assign pd_oe_n_o = st_ff.pd_oe_n;
  assign serial_ch10_receive_o = st_ff.rx[0];
  assign serial_ch11_receive_o = st_ff.rx[1];
  assign serial_ch10_clock_o = st_ff.sclk_in[0];
  assign serial_ch11_clock_o = st_ff.sclk_in[1];
  assign serial_ch10_clear_to_send_o = st_ff.cts[0];
  assign serial_ch11_clear_to_send_o = st_ff.cts[1];
  assign external_interrupt_input_o = st_ff.ext_int;
  assign portc_open_drain_o = st_ff.c_open_drain;
  assign portc_pullup_o = st_ff.c_pullup;
  assign portc_input_en_o = st_ff.c_input_en;

endmodule // gpc_port

// ==== gpc_port_asserts.sv ====
`timescale 1ns/1ns
module gpc_port_asserts
  import gpc_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [7:0] pd_oe_n_o,
  input wire logic [7:0] portc_open_drain_o,
  input wire logic [7:0] portc_pullup_o,
  input wire logic [7:0] portc_input_en_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========
  // register bus and pad relations
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rst;
    $rose(rst_n_i) |-> pd_oe_n_o == 8'hff && (portc_open_drain_o | portc_pullup_o | portc_input_en_o) == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pads not off after reset");
  property p_oe;
    wr_i && addr_i == 32'h400c0304 |-> ##2 &(pd_oe_n_o | 8'($past(wdata_i, 2)));
  endproperty
  a_oe: assert property (p_oe) else $error("driver on with direction zero");
  property p_fs_two;
    rd_i && addr_i == 32'h400c030c |=> !rdata_o[3];
  endproperty
  a_fs_two: assert property (p_fs_two) else $error("reserved bit 3 set");
  property p_fs_three;
    rd_i && addr_i == 32'h400c0310 |=> (rdata_o & ~32'h44) == '0;
  endproperty
  a_fs_three: assert property (p_fs_three) else $error("reserved bits set");
  property p_od;
    wr_i && addr_i == 32'h400c0228 ##1 !wr_i |=> portc_open_drain_o == 8'($past(wdata_i, 2));
  endproperty
  a_od: assert property (p_od) else $error("open drain select wrong");
  property p_pu;
    wr_i && addr_i == 32'h400c022c ##1 !wr_i |=> portc_pullup_o == 8'($past(wdata_i, 2));
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up enable wrong");
  property p_ie;
    wr_i && addr_i == 32'h400c0238 ##1 !wr_i |=> portc_input_en_o == 8'($past(wdata_i, 2));
  endproperty
  a_ie: assert property (p_ie) else $error("input enable wrong");
endmodule // gpc_port_asserts

bind gpc_port gpc_port_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) gpc_port_asserts_i (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pd_oe_n_o(pd_oe_n_o), .portc_open_drain_o(portc_open_drain_o), .portc_pullup_o(portc_pullup_o),
  .portc_input_en_o(portc_input_en_o));

// ==== gpc_pad_model.sv ====
`timescale 1ns/1ns
module gpc_pad_model
  import gpc_pkg::*;
(
  input wire gpc_byte_t pad_out_i,
  input wire gpc_byte_t pad_oe_n_i,
  input wire gpc_byte_t far_level_i,
  output gpc_byte_t pin_o
);
  // ==========
  // pin level: own driver wins, else far side level
  assign pin_o = (pad_out_i & ~pad_oe_n_i) | (far_level_i & pad_oe_n_i);
endmodule // gpc_pad_model

// ==== test_gpc_port.sv ====
`timescale 1ns/1ns
`define CHK(n, x, y) begin checked++; if ((y) !== (x)) begin failures++; $display("ERROR %s exp %h got %h", n, x, y); end end
module test_gpc_port
  import gpc_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic [31:0] rdata_o;
  logic [31:0] rv;
  logic [31:0] regs [7] = '{32'h400c0228, 32'h400c022c, 32'h400c0238, 32'h400c0304,
    32'h400c0308, 32'h400c030c, 32'h400c0310};
  gpc_byte_t ext_addr_i = '0;
  gpc_byte_t far = '0;
  gpc_byte_t pd_in_i, pd_out_o, pd_oe_n_o, od, pu, ie, a, e, d;
  logic [1:0] tx = '0;
  logic [1:0] ck = '0;
  logic [1:0] ckoe = '0;
  logic rx10, rx11, ck10, ck11, cts10, cts11, eint;
  int failures = 0;
  int checked = 0;

  // ==========
  // design and pads
  gpc_port gpc_port_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pd_in_i(pd_in_i), .pd_out_o(pd_out_o), .pd_oe_n_o(pd_oe_n_o),
    .ext_addr_i(ext_addr_i), .serial_ch10_transmit_i(tx[0]), .serial_ch11_transmit_i(tx[1]),
    .serial_ch10_clock_out_i(ck[0]), .serial_ch11_clock_out_i(ck[1]), .serial_ch10_clock_oe_i(ckoe[0]),
    .serial_ch11_clock_oe_i(ckoe[1]), .serial_ch10_receive_o(rx10), .serial_ch11_receive_o(rx11),
    .serial_ch10_clock_o(ck10), .serial_ch11_clock_o(ck11), .serial_ch10_clear_to_send_o(cts10),
    .serial_ch11_clear_to_send_o(cts11), .external_interrupt_input_o(eint), .portc_open_drain_o(od),
    .portc_pullup_o(pu), .portc_input_en_o(ie));
  gpc_pad_model gpc_pad_model_i (.pad_out_i(pd_out_o), .pad_oe_n_i(pd_oe_n_o), .far_level_i(far),
    .pin_o(pd_in_i));

  // ==========
  // clock, bus tasks, expectations
  initial
  begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic wr(input logic [31:0] ad, input gpc_byte_t dt);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= {24'($urandom()), dt};
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] ad, output logic [31:0] v);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  function automatic gpc_byte_t rmask(input int k);
    rmask = (k == 5) ? 8'hf7 : (k == 6) ? 8'h44 : 8'hff;
  endfunction

  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    complete_run();
  end

  // ==========
  // scenarios
  initial
  begin
    void'($urandom(32'h03cf));
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK("reset oe_n", 8'hff, pd_oe_n_o)
    `CHK("reset in", 7'b1111000, {rx11, rx10, cts11, cts10, eint, ck11, ck10})
    for (int i = 0; i < 7; i++)
    begin
      rd(regs[i], rv);
      `CHK("reset reg", 32'h0, rv)
    end
    for (int r = 0; r < 14; r++)
    begin
      d = (r < 7) ? 8'hff : 8'($urandom());
      wr(regs[r % 7], d);
      rd(regs[r % 7], rv);
      `CHK("readback", {24'h0, d & rmask(r % 7)}, rv)
    end
    wr(32'h400c0314, 8'hff);
    rd(32'h400c0314, rv);
    `CHK("unmapped", 32'h0, rv)
    a = 8'($urandom());
    e = 8'($urandom());
    d = 8'($urandom());
    wr(regs[0], a);
    wr(regs[1], e);
    wr(regs[2], d);
    @(posedge sys_clk_i);
    #1;
    `CHK("port c", {a, e, d}, {od, pu, ie})
    wr(regs[5], 8'h00);
    wr(regs[6], 8'h00);
    far <= 8'($urandom());
    ext_addr_i <= 8'($urandom());
    a = 8'($urandom());
    e = 8'($urandom());
    d = 8'($urandom());
    wr(regs[4], a);
    wr(regs[3], e);
    wr(32'h400c0300, d);
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("pad oe_n", ~e, pd_oe_n_o)
    `CHK("pad out", ((a & ext_addr_i) | (~a & d)) & e, pd_out_o & e)
    rd(32'h400c0300, rv);
    `CHK("pin read", {24'h0, (d & e) | (far & ~e)}, rv)
    wr(regs[4], 8'h00);
    wr(regs[3], 8'hff);
    tx <= 2'($urandom());
    ck <= 2'($urandom());
    ckoe <= 2'b11;
    far <= 8'($urandom());
    wr(regs[5], 8'hff);
    repeat (7) @(posedge sys_clk_i);
    #1;
    `CHK("alt oe_n", 8'ha2, pd_oe_n_o)
    `CHK("alt out", {1'b0, ck[1], 1'b0, tx[1], d[3], ck[0], 1'b0, tx[0]}, pd_out_o & 8'h5d)
    `CHK("alt in", {far[7], far[5], far[1], ck}, {eint, rx11, rx10, ck11, ck10})
    @(posedge sys_clk_i);
    ckoe <= 2'b00;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("clock release", 8'he6, pd_oe_n_o)
    wr(regs[5], 8'h00);
    wr(regs[3], 8'h00);
    far <= 8'($urandom());
    wr(regs[6], 8'hff);
    repeat (7) @(posedge sys_clk_i);
    #1;
    `CHK("cts in", {far[6], far[2], 5'b11000}, {cts11, cts10, rx11, rx10, eint, ck11, ck10})
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(regs[6], rv);
    `CHK("second reset", {32'h0, 8'hff}, {rv, pd_oe_n_o})
    complete_run();
  end
endmodule // test_gpc_port
